// >>> core/cpu_pkg.sv
// Shared constants for the sensor CPU core
package cpu_pkg;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int SEL_W = 4;
  localparam int OPC_W = 4;
  localparam int NUM_REGS = 16;
  localparam int PROG_ADDR_W = 16;
  localparam int PROG_USED_W = 12;
  localparam int PAD_W = PROG_ADDR_W - PROG_USED_W;

  localparam int OPC_MSB = 7;
  localparam int OPC_LSB = 4;
  localparam int SEL_MSB = 3;
  localparam int SEL_LSB = 0;

  localparam logic [OPC_W-1:0] OP_LOAD_IMMEDIATE = 4'h0;
  localparam logic [OPC_W-1:0] OP_CLEAR_REGISTER = 4'h1;
  localparam logic [OPC_W-1:0] OP_AND_INTO_ACCUMULATOR = 4'h2;
  localparam logic [OPC_W-1:0] OP_OR_INTO_ACCUMULATOR = 4'h3;
  localparam logic [OPC_W-1:0] OP_ADD_INTO_ACCUMULATOR = 4'h4;
  localparam logic [OPC_W-1:0] OP_STORE_ACCUMULATOR = 4'h5;
  localparam logic [OPC_W-1:0] OP_SHIFT_LEFT_REGISTER = 4'h6;
  localparam logic [OPC_W-1:0] OP_SHIFT_RIGHT_ARITH = 4'h7;

  localparam logic [SEL_W-1:0] LINKED_SHIFT_SEL = 4'h6;
  localparam logic [SEL_W-1:0] SHIFT_FEED_SEL = 4'h4;

  localparam logic [PROG_USED_W-1:0] RESET_PC = 12'h000;
  localparam logic [PROG_USED_W-1:0] PC_STEP = 12'h001;
  localparam logic [PAD_W-1:0] ADDR_PAD = 4'h0;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [DATA_W-1:0] ACC_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [SEL_W-1:0] ZERO_SEL = 4'h0;
  localparam logic [OPC_W-1:0] ZERO_OPC = 4'h0;
  localparam logic [DATA_W-1:0] COUNT_STEP = 16'h0001;
endpackage

// >>> core/reg_bank.sv
// Sixteen general registers with one execute read port and one debug port
`timescale 1ns/1ns
module reg_bank #(
  parameter int DATA_W = cpu_pkg::DATA_W,
  parameter int SEL_W = cpu_pkg::SEL_W,
  parameter int NUM_REGS = cpu_pkg::NUM_REGS
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [SEL_W-1:0] wr_sel,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [SEL_W-1:0] rd_sel,
  output logic [DATA_W-1:0] rd_data,
  output logic feed_msb,
  input wire logic [SEL_W-1:0] dbg_sel,
  output logic [DATA_W-1:0] dbg_data
);
  logic [DATA_W-1:0] regs_reg [NUM_REGS];

  // Execute read is combinational so single-cycle ops need no extra fetch slot
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          regs_reg[gi] <= cpu_pkg::REG_RESET;
        end else if (wr_en && wr_sel == SEL_W'(gi)) begin
          regs_reg[gi] <= wr_data;
        end
      end
    end
  endgenerate

  assign rd_data = regs_reg[rd_sel];
  assign feed_msb = regs_reg[cpu_pkg::SHIFT_FEED_SEL][DATA_W-1];

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dbg_data <= cpu_pkg::REG_RESET;
    end else begin
      dbg_data <= regs_reg[dbg_sel];
    end
  end
endmodule

// >>> core/alu_unit.sv
// Result logic for the single-cycle register and accumulator instructions
`timescale 1ns/1ns
module alu_unit #(
  parameter int DATA_W = cpu_pkg::DATA_W,
  parameter int SEL_W = cpu_pkg::SEL_W,
  parameter int OPC_W = cpu_pkg::OPC_W
) (
  input wire logic [OPC_W-1:0] opcode,
  input wire logic [SEL_W-1:0] sel,
  input wire logic [DATA_W-1:0] acc,
  input wire logic [DATA_W-1:0] xval,
  input wire logic feed_msb,
  output logic acc_we,
  output logic [DATA_W-1:0] acc_result,
  output logic reg_we,
  output logic [DATA_W-1:0] reg_result
);
  always_comb begin
    acc_we = 1'h0;
    acc_result = acc;
    reg_we = 1'h0;
    reg_result = xval;
    case (opcode)
      cpu_pkg::OP_CLEAR_REGISTER: begin
        reg_we = 1'h1;
        reg_result = cpu_pkg::ZERO_WORD;
      end
      cpu_pkg::OP_AND_INTO_ACCUMULATOR: begin
        acc_we = 1'h1;
        acc_result = acc & xval;
      end
      cpu_pkg::OP_OR_INTO_ACCUMULATOR: begin
        acc_we = 1'h1;
        acc_result = acc | xval;
      end
      cpu_pkg::OP_ADD_INTO_ACCUMULATOR: begin
        acc_we = 1'h1;
        acc_result = DATA_W'(acc + xval);
      end
      cpu_pkg::OP_STORE_ACCUMULATOR: begin
        reg_we = 1'h1;
        reg_result = acc;
      end
      cpu_pkg::OP_SHIFT_LEFT_REGISTER: begin
        reg_we = 1'h1;
        if (sel == cpu_pkg::LINKED_SHIFT_SEL) begin
          reg_result = {xval[DATA_W-2:0], feed_msb};
        end else begin
          reg_result = {xval[DATA_W-2:0], 1'h0};
        end
      end
      cpu_pkg::OP_SHIFT_RIGHT_ARITH: begin
        reg_we = 1'h1;
        reg_result = {xval[DATA_W-1], xval[DATA_W-1:1]};
      end
      default: begin
        acc_we = 1'h0;
        reg_we = 1'h0;
      end
    endcase
  end
endmodule

// >>> core/sensor_cpu_core.sv
// Instruction fetch, decode and execute core of the sensor CPU
// What this block does
// - Byte is opcode nibble plus selector nibble
// - Start at 0000h, step one byte upward
// - Only low 12 address bits used
// - Immediate load: two bytes, high first, three cycles
// - Clear selected register in one cycle
// - Accumulator ANDed with selected register
// - Accumulator ORed with selected register
// - Add register to accumulator, drop carry
// - Copy accumulator into selected register
// - Shift left, zero into bit 0
// - Register six shift fills from register four
// - Arithmetic right shift keeps sign bit
// - Other instructions: one cycle, PC plus one
// - Selector reaches all sixteen registers
// - Sequential flow, only destination modified
// - Program memory read only, partition zero
`timescale 1ns/1ns
module sensor_cpu_core #(
  parameter int DATA_W = cpu_pkg::DATA_W,
  parameter int BYTE_W = cpu_pkg::BYTE_W,
  parameter int SEL_W = cpu_pkg::SEL_W,
  parameter int OPC_W = cpu_pkg::OPC_W,
  parameter int ADDR_W = cpu_pkg::PROG_USED_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  output logic [cpu_pkg::PROG_ADDR_W-1:0] prog_addr,
  output logic prog_rd_en,
  input wire logic [BYTE_W-1:0] prog_data,
  input wire logic [SEL_W-1:0] dbg_sel,
  output logic [DATA_W-1:0] dbg_data,
  output logic [DATA_W-1:0] acc_data,
  output logic retire,
  output logic [OPC_W-1:0] retire_opcode,
  output logic [ADDR_W-1:0] retire_pc,
  output logic wr_strobe,
  output logic [SEL_W-1:0] wr_sel,
  output logic [DATA_W-1:0] wr_value,
  output logic load_busy,
  output logic [DATA_W-1:0] retired_count
);
  typedef enum logic [2:0] {
    ST_START,
    ST_PRIME,
    ST_EXEC,
    ST_LOAD_HI,
    ST_LOAD_LO
  } core_state_e;

  function automatic logic [OPC_W-1:0] opcode_of(input logic [BYTE_W-1:0] b);
    opcode_of = b[cpu_pkg::OPC_MSB:cpu_pkg::OPC_LSB];
  endfunction

  function automatic logic [SEL_W-1:0] sel_of(input logic [BYTE_W-1:0] b);
    sel_of = b[cpu_pkg::SEL_MSB:cpu_pkg::SEL_LSB];
  endfunction

  function automatic logic is_load(input logic [BYTE_W-1:0] b);
    is_load = (opcode_of(b) == cpu_pkg::OP_LOAD_IMMEDIATE);
  endfunction

  core_state_e state_reg;
  core_state_e state_next;
  logic [ADDR_W-1:0] fetch_addr_reg;
  logic [ADDR_W-1:0] instr_pc;
  logic [ADDR_W-1:0] ld_pc_reg;
  logic [SEL_W-1:0] ld_sel_reg;
  logic [BYTE_W-1:0] ld_hi_reg;
  logic [DATA_W-1:0] acc_reg;
  logic [OPC_W-1:0] cur_op;
  logic [SEL_W-1:0] cur_sel;
  logic exec_now;
  logic exec_single;
  logic exec_load;
  logic finish_load;
  logic retire_now;
  logic [DATA_W-1:0] xval;
  logic feed_msb;
  logic alu_acc_we;
  logic [DATA_W-1:0] alu_acc_result;
  logic alu_reg_we;
  logic [DATA_W-1:0] alu_reg_result;
  logic bank_we;
  logic [SEL_W-1:0] bank_sel;
  logic [DATA_W-1:0] bank_wdata;

  assign cur_op = opcode_of(prog_data);
  assign cur_sel = sel_of(prog_data);
  assign exec_now = (state_reg == ST_EXEC);
  assign exec_load = exec_now && is_load(prog_data);
  assign exec_single = exec_now && !is_load(prog_data);
  assign finish_load = (state_reg == ST_LOAD_LO);
  assign retire_now = exec_single || finish_load;
  // The byte on prog_data was addressed one edge earlier
  assign instr_pc = ADDR_W'(fetch_addr_reg - cpu_pkg::PC_STEP);

  reg_bank #(
    .DATA_W(DATA_W),
    .SEL_W(SEL_W),
    .NUM_REGS(cpu_pkg::NUM_REGS)
  ) u_bank (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wr_en(bank_we),
    .wr_sel(bank_sel),
    .wr_data(bank_wdata),
    .rd_sel(cur_sel),
    .rd_data(xval),
    .feed_msb(feed_msb),
    .dbg_sel(dbg_sel),
    .dbg_data(dbg_data)
  );

  alu_unit #(
    .DATA_W(DATA_W),
    .SEL_W(SEL_W),
    .OPC_W(OPC_W)
  ) u_alu (
    .opcode(cur_op),
    .sel(cur_sel),
    .acc(acc_reg),
    .xval(xval),
    .feed_msb(feed_msb),
    .acc_we(alu_acc_we),
    .acc_result(alu_acc_result),
    .reg_we(alu_reg_we),
    .reg_result(alu_reg_result)
  );

  // Load completion and single-cycle ops never coincide, so one write port is enough
  always_comb begin
    bank_we = 1'h0;
    bank_sel = cur_sel;
    bank_wdata = alu_reg_result;
    if (finish_load) begin
      bank_we = 1'h1;
      bank_sel = ld_sel_reg;
      bank_wdata = {ld_hi_reg, prog_data};
    end else if (exec_single) begin
      bank_we = alu_reg_we;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_START: begin
        state_next = ST_PRIME;
      end
      ST_PRIME: begin
        state_next = ST_EXEC;
      end
      ST_EXEC: begin
        if (exec_load) begin
          state_next = ST_LOAD_HI;
        end
      end
      ST_LOAD_HI: begin
        state_next = ST_LOAD_LO;
      end
      ST_LOAD_LO: begin
        state_next = ST_EXEC;
      end
      default: begin
        state_next = ST_START;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg <= ST_START;
    end else begin
      state_reg <= state_next;
    end
  end

  // Address runs one byte ahead of execution so a fetch lands every cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fetch_addr_reg <= cpu_pkg::RESET_PC;
    end else if (state_reg != ST_START) begin
      fetch_addr_reg <= ADDR_W'(fetch_addr_reg + cpu_pkg::PC_STEP);
    end
  end

  // Upper four address bits are always zero; wrap past 0FFFh is to 0000h
  assign prog_addr = {cpu_pkg::ADDR_PAD, fetch_addr_reg};

  // No write, erase or partition path exists here; the port is read only
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      prog_rd_en <= 1'h0;
    end else begin
      prog_rd_en <= 1'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ld_sel_reg <= cpu_pkg::ZERO_SEL;
    end else if (exec_load) begin
      ld_sel_reg <= cur_sel;
    end
  end

  // Kept apart from the live pc because retire reports the load two edges later
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ld_pc_reg <= cpu_pkg::RESET_PC;
    end else if (exec_load) begin
      ld_pc_reg <= instr_pc;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ld_hi_reg <= cpu_pkg::ZERO_BYTE;
    end else if (state_reg == ST_LOAD_HI) begin
      ld_hi_reg <= prog_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      acc_reg <= cpu_pkg::ACC_RESET;
    end else if (exec_single && alu_acc_we) begin
      acc_reg <= alu_acc_result;
    end
  end

  assign acc_data = acc_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      retire <= 1'h0;
    end else begin
      retire <= retire_now;
    end
  end

  // A load retires at its last operand edge, when prog_data no longer holds its opcode
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      retire_opcode <= cpu_pkg::ZERO_OPC;
    end else if (exec_single) begin
      retire_opcode <= cur_op;
    end else if (finish_load) begin
      retire_opcode <= cpu_pkg::OP_LOAD_IMMEDIATE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      retire_pc <= cpu_pkg::RESET_PC;
    end else if (exec_single) begin
      retire_pc <= instr_pc;
    end else if (finish_load) begin
      retire_pc <= ld_pc_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wr_strobe <= 1'h0;
    end else begin
      wr_strobe <= bank_we;
    end
  end

  // Index and value hold after the pulse so the last write stays visible
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wr_sel <= cpu_pkg::ZERO_SEL;
    end else if (bank_we) begin
      wr_sel <= bank_sel;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wr_value <= cpu_pkg::ZERO_WORD;
    end else if (bank_we) begin
      wr_value <= bank_wdata;
    end
  end

  // Taken from the next state so the flag covers exactly the two operand cycles
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      load_busy <= 1'h0;
    end else begin
      load_busy <= (state_next == ST_LOAD_HI) || (state_next == ST_LOAD_LO);
    end
  end

  // Counter wraps silently; it is an observation aid only
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      retired_count <= cpu_pkg::ZERO_WORD;
    end else if (retire_now) begin
      retired_count <= DATA_W'(retired_count + cpu_pkg::COUNT_STEP);
    end
  end
endmodule

// >>> sim/prog_flash_model.sv
// Program flash model with a one-cycle registered byte read
`timescale 1ns/1ns
module prog_flash_model (
  input wire logic clk_sys,
  input wire logic [15:0] prog_addr,
  input wire logic prog_rd_en,
  output logic [7:0] prog_data
);
  logic [7:0] mem [0:4095];
  logic [7:0] data_reg = 8'h5A;
  assign prog_data = data_reg;
  // Read only, partition zero, low 12 address bits decoded
  always_ff @(posedge clk_sys) begin
    if (prog_rd_en) begin
      data_reg <= mem[prog_addr[11:0]];
    end else begin
      // Idle port toggles so a stale byte never looks valid
      data_reg <= ~data_reg;
    end
  end
endmodule

// >>> sim/cpu_core_chk.sv
// Port-level checker for the sensor CPU core
`timescale 1ns/1ns
module cpu_core_chk #(
  parameter int DATA_W = 16,
  parameter int SEL_W = 4,
  parameter int OPC_W = 4,
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [cpu_pkg::PROG_ADDR_W-1:0] prog_addr,
  input wire logic prog_rd_en,
  input wire logic [DATA_W-1:0] acc_data,
  input wire logic retire,
  input wire logic [OPC_W-1:0] retire_opcode,
  input wire logic [ADDR_W-1:0] retire_pc,
  input wire logic wr_strobe,
  input wire logic [SEL_W-1:0] wr_sel,
  input wire logic [DATA_W-1:0] wr_value,
  input wire logic load_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence load_end;
    !load_busy && retire && retire_opcode == cpu_pkg::OP_LOAD_IMMEDIATE && wr_strobe;
  endsequence
  sequence load_hold;
    load_busy ##1 load_end;
  endsequence
  addr_upper_a: assert property (prog_addr[cpu_pkg::PROG_ADDR_W-1:ADDR_W] == '0)
    else $error("upper program address bits set");
  addr_step_a: assert property (prog_rd_en && $past(prog_rd_en) |->
    prog_addr[ADDR_W-1:0] == $past(prog_addr[ADDR_W-1:0]) + ADDR_W'(1)) else $error("fetch address not sequential");
  load_span_a: assert property ($rose(load_busy) |=> load_hold)
    else $error("immediate load not three cycles");
  pc_step_a: assert property (retire ##1 retire |-> retire_pc == $past(retire_pc) +
    (($past(retire_opcode) == cpu_pkg::OP_LOAD_IMMEDIATE) ? ADDR_W'(3) : ADDR_W'(1))) else $error("pc step wrong");
  clear_zero_a: assert property (retire && retire_opcode == cpu_pkg::OP_CLEAR_REGISTER |->
    wr_strobe && wr_value == cpu_pkg::ZERO_WORD) else $error("clear did not write zero");
  store_acc_a: assert property (retire && retire_opcode == cpu_pkg::OP_STORE_ACCUMULATOR |->
    wr_strobe && wr_value == acc_data && $stable(acc_data)) else $error("store value wrong");
  acc_only_a: assert property (retire && (retire_opcode inside {[4'h2:4'h4]} || retire_opcode[3]) |->
    !wr_strobe) else $error("unexpected register write");
  acc_keep_a: assert property (retire && retire_opcode inside {4'h0, 4'h1, 4'h6, 4'h7} |->
    $stable(acc_data)) else $error("accumulator changed");
  shl_zero_a: assert property (retire && retire_opcode == cpu_pkg::OP_SHIFT_LEFT_REGISTER &&
    wr_sel != cpu_pkg::LINKED_SHIFT_SEL |-> wr_strobe && !wr_value[0]) else $error("shift left fill wrong");
  shr_sign_a: assert property (retire && retire_opcode == cpu_pkg::OP_SHIFT_RIGHT_ARITH |->
    wr_strobe && wr_value[15] == wr_value[14]) else $error("shift right sign wrong");
endmodule
bind sensor_cpu_core cpu_core_chk #(.DATA_W(DATA_W), .SEL_W(SEL_W), .OPC_W(OPC_W), .ADDR_W(ADDR_W)) u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .prog_addr(prog_addr), .prog_rd_en(prog_rd_en), .acc_data(acc_data),
  .retire(retire), .retire_opcode(retire_opcode), .retire_pc(retire_pc), .wr_strobe(wr_strobe),
  .wr_sel(wr_sel), .wr_value(wr_value), .load_busy(load_busy));

// >>> sim/sensor_cpu_core_alu_ops_tb.sv
// Self-checking bench for the sensor CPU core
`timescale 1ns/1ns
module sensor_cpu_core_alu_ops_tb;
  logic clk_sys = 1'h0;
  logic rst_b = 1'h0;
  logic [3:0] dbg_sel = 4'h0;
  logic [15:0] prog_addr, dbg_data, acc_data, retired_count;
  logic prog_rd_en;
  logic [7:0] prog_data;
  logic [7:0] prog [$];
  int n_fail = 0;
  int n_compared = 0;
  always #20 clk_sys = ~clk_sys;
  prog_flash_model u_prog_flash_model (.clk_sys(clk_sys), .prog_addr(prog_addr), .prog_rd_en(prog_rd_en),
    .prog_data(prog_data));
  sensor_cpu_core u_sensor_cpu_core (.clk_sys(clk_sys), .rst_b(rst_b), .prog_addr(prog_addr),
    .prog_rd_en(prog_rd_en), .prog_data(prog_data), .dbg_sel(dbg_sel), .dbg_data(dbg_data),
    .acc_data(acc_data), .retire(), .retire_opcode(), .retire_pc(), .wr_strobe(), .wr_sel(), .wr_value(),
    .load_busy(), .retired_count(retired_count));
  task automatic end_sim;
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Unused bytes are no-ops so the core idles harmlessly after the program
  task automatic run_prog(input int n, input logic [7:0] last);
    @(posedge clk_sys);
    rst_b <= 1'h0;
    for (int i = 0; i < 4096; i++) u_prog_flash_model.mem[i] = (i < prog.size()) ? prog[i] : 8'h80;
    u_prog_flash_model.mem[4095] = last;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'h1;
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic read_reg(input logic [3:0] s, input logic [15:0] exp);
    @(posedge clk_sys);
    dbg_sel <= s;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk16(dbg_data, exp);
  endtask
  task automatic s_load_all;
    prog = {};
    for (int i = 0; i < 16; i++) begin
      prog.push_back({4'h0, 4'(i)});
      prog.push_back({4'hA, 4'(i)});
      prog.push_back({4'(i), 4'h5});
    end
    run_prog(56, 8'h80);
    for (int i = 0; i < 16; i++) read_reg(4'(i), {4'hA, 4'(i), 4'(i), 4'h5});
  endtask
  task automatic s_alu;
    prog = '{8'h01, 8'hF0, 8'hF0, 8'h02, 8'h0F, 8'hF3, 8'h03, 8'hFF, 8'h20, 8'h31, 8'h22, 8'h43, 8'h55, 8'h11};
    run_prog(20, 8'h80);
    @(negedge clk_sys);
    chk16(acc_data, 16'h0010);
    chk16(retired_count, 16'h000C);
    read_reg(4'h5, 16'h0010);
    read_reg(4'h1, 16'h0000);
    read_reg(4'h2, 16'h0FF3);
    read_reg(4'h3, 16'hFF20);
  endtask
  task automatic s_shift;
    prog = '{8'h04, 8'h80, 8'h01, 8'h06, 8'h40, 8'h00, 8'h07, 8'h80, 8'h03, 8'h09, 8'hC0, 8'h01, 8'h66, 8'h67,
      8'h79};
    run_prog(22, 8'h80);
    read_reg(4'h6, 16'h8001);
    read_reg(4'h4, 16'h8001);
    read_reg(4'h7, 16'h0006);
    read_reg(4'h9, 16'hE000);
  endtask
  // Load at the last address takes its operand across the wrap to 0000h
  task automatic s_wrap;
    prog = '{8'hC3, 8'h45};
    run_prog(4106, 8'h0A);
    read_reg(4'hA, 16'hC345);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'h1;
    s_load_all();
    s_alu();
    s_shift();
    s_wrap();
    end_sim();
  end
  initial begin
    repeat (8000) @(posedge clk_sys);
    n_fail++;
    end_sim();
  end
endmodule
